// >>> hw/sam_conv.sv
// Serial converter addressing, frame sequencing and result shifting
// Notes on behaviour
// - Positive below negative gives all-zero code
// - Assignment word captured from serial input
// - Config one single-ended; polarity picks channel
// - Differential polarity swaps positive and negative
// - One-channel variant takes no address bits
// - Configuration latched before conversion begins
// - Fresh configuration accepted every frame that opens with room in the buffer
// - Frame lasts eleven or twenty clocks
// - First one while selected is start
// - Next two bits: config, then polarity
// - Half-clock settle, then leading zero driven
// - MSB first, LSB repeat in the two-channel variant only, then low
`timescale 1ns/100ps
`default_nettype none
module sam_conv
    import sam_pkg::*;
#(
    parameter bit TWO_CHAN = 1'b1
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // Serial link pins
    input  wire logic                  sclk,
    input  wire logic                  cs_n,
    input  wire logic                  serial_in,
    output var  logic                  serial_out,
    output var  logic                  serial_out_oe,
    // Sampled analog levels as codes
    input  wire logic [SAM_CODE_W-1:0] ain0,
    input  wire logic [SAM_CODE_W-1:0] ain1,
    // Result stream
    output var  logic                  res_valid,
    input  wire logic                  res_ready,
    output var  sam_result_t           res_data
);
    logic [2:0]            sclk_s_r;
    logic [2:0]            csn_s_r;
    logic [2:0]            din_s_r;
    logic [2:0]            sync_nxt [3];
    logic                  sclk_lvl_r;
    logic                  sclk_lvl_nxt;
    logic                  csn_lvl_r;
    logic                  csn_lvl_nxt;
    logic                  din_lvl_r;
    logic                  din_lvl_nxt;
    logic                  rise;
    logic                  fall;

    sam_state_t            state_r;
    sam_state_t            state_nxt;
    logic [3:0]            cnt_r;
    logic [3:0]            cnt_nxt;
    logic                  single_r;
    logic                  single_nxt;
    logic [SAM_CODE_W-1:0] code_r;
    logic [SAM_CODE_W-1:0] code_nxt;
    logic                  do_nxt;
    logic                  oe_nxt;
    logic                  push;
    logic                  buf_ready;
    sam_result_t           push_word;
    logic [SAM_RESULT_W-1:0] buf_out;

    // Settled level follows once second and third stages agree
    function automatic logic filt(input logic [2:0] s, input logic lvl);
        filt = (s[1] == s[2]) ? s[2] : lvl;
    endfunction

    // Conversion of the selected pair
    function automatic logic [SAM_CODE_W-1:0] convert(
        input logic single, input logic pol,
        input logic [SAM_CODE_W-1:0] a0, input logic [SAM_CODE_W-1:0] a1);
        logic [SAM_CODE_W-1:0] pos;
        logic [SAM_CODE_W-1:0] neg;
        pos = pol ? a1 : a0;
        neg = single ? SAM_CODE_RST : (pol ? a0 : a1);
        convert = (pos < neg) ? SAM_CODE_RST : pos - neg;
    endfunction

    always_comb begin
        sync_nxt[0]  = {sclk_s_r[1:0], sclk};
        sync_nxt[1]  = {csn_s_r[1:0], cs_n};
        sync_nxt[2]  = {din_s_r[1:0], serial_in};
        sclk_lvl_nxt = filt(sclk_s_r, sclk_lvl_r);
        csn_lvl_nxt  = filt(csn_s_r, csn_lvl_r);
        din_lvl_nxt  = filt(din_s_r, din_lvl_r);
        rise         = sclk_lvl_nxt && !sclk_lvl_r;
        fall         = !sclk_lvl_nxt && sclk_lvl_r;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_s_r   <= SAM_SYNC_RST;
            csn_s_r    <= {3{SAM_CSN_RST}};
            din_s_r    <= SAM_SYNC_RST;
            sclk_lvl_r <= 1'b0;
            csn_lvl_r  <= SAM_CSN_RST;
            din_lvl_r  <= 1'b0;
        end else begin
            sclk_s_r   <= sync_nxt[0];
            csn_s_r    <= sync_nxt[1];
            din_s_r    <= sync_nxt[2];
            sclk_lvl_r <= sclk_lvl_nxt;
            csn_lvl_r  <= csn_lvl_nxt;
            din_lvl_r  <= din_lvl_nxt;
        end
    end

    // Frame sequencer
    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        single_nxt = single_r;
        code_nxt   = code_r;
        do_nxt     = serial_out;
        oe_nxt     = serial_out_oe;
        push       = 1'b0;
        push_word  = '{code: code_r, single: single_r, polarity: 1'b0};
        if (csn_lvl_nxt) begin
            state_nxt = SAM_IDLE;
            oe_nxt    = 1'b0;
            do_nxt    = 1'b0;
        end else begin
            case (state_r)
                SAM_IDLE: begin
                    // Frame only opens with room for its result
                    if (buf_ready) begin
                        state_nxt = SAM_START;
                    end
                end
                SAM_START: begin
                    if (rise && din_lvl_nxt) begin
                        if (TWO_CHAN) begin
                            state_nxt = SAM_ADDR;
                            cnt_nxt   = '0;
                        end else begin
                            // Fixed pair, channel 0 positive
                            single_nxt = 1'b0;
                            code_nxt   = convert(1'b0, 1'b0, ain0, ain1);
                            push_word  = '{code: code_nxt, single: 1'b0,
                                           polarity: 1'b0};
                            push       = 1'b1;
                            state_nxt  = SAM_SETTLE;
                        end
                    end
                end
                SAM_ADDR: begin
                    if (rise) begin
                        if (cnt_r == '0) begin
                            single_nxt = din_lvl_nxt;
                            cnt_nxt    = cnt_r + 4'h1;
                        end else begin
                            code_nxt  = convert(single_r, din_lvl_nxt,
                                                ain0, ain1);
                            push_word = '{code: code_nxt,
                                          single: single_r,
                                          polarity: din_lvl_nxt};
                            push      = 1'b1;
                            state_nxt = SAM_SETTLE;
                        end
                    end
                end
                SAM_SETTLE: begin
                    // Input ignored; output opens on the next fall
                    if (fall) begin
                        oe_nxt    = 1'b1;
                        do_nxt    = 1'b0;
                        cnt_nxt   = SAM_CNT_MSB;
                        state_nxt = SAM_MSB;
                    end
                end
                SAM_MSB: begin
                    if (fall) begin
                        do_nxt = code_r[cnt_r[2:0]];
                        if (cnt_r == '0) begin
                            cnt_nxt   = SAM_CNT_LSB0;
                            state_nxt = TWO_CHAN ? SAM_LSB : SAM_TAIL;
                        end else begin
                            cnt_nxt = cnt_r - 4'h1;
                        end
                    end
                end
                SAM_LSB: begin
                    if (fall) begin
                        do_nxt = code_r[cnt_r[2:0]];
                        if (cnt_r == SAM_CNT_LAST) begin
                            state_nxt = SAM_TAIL;
                        end else begin
                            cnt_nxt = cnt_r + 4'h1;
                        end
                    end
                end
                SAM_TAIL: begin
                    if (fall) begin
                        do_nxt = 1'b0;
                    end
                end
                default: begin
                    state_nxt = SAM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r       <= SAM_IDLE;
            cnt_r         <= '0;
            single_r      <= 1'b0;
            code_r        <= SAM_CODE_RST;
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            state_r       <= state_nxt;
            cnt_r         <= cnt_nxt;
            single_r      <= single_nxt;
            code_r        <= code_nxt;
            serial_out    <= do_nxt;
            serial_out_oe <= oe_nxt;
        end
    end

    sam_buf2 #(
        .WIDTH (SAM_RESULT_W)
    ) u_buf (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (push),
        .in_ready  (buf_ready),
        .in_data   (push_word),
        .out_valid (res_valid),
        .out_ready (res_ready),
        .out_data  (buf_out)
    );

    assign res_data = sam_result_t'(buf_out);
endmodule
`default_nettype wire

// >>> hw/sam_pkg.sv
// Shared constants and types for the serial converter frame logic
package sam_pkg;
    localparam int          SAM_CODE_W    = 8;
    localparam logic [3:0]  SAM_CNT_MSB   = 4'h7;
    localparam logic [3:0]  SAM_CNT_LSB0  = 4'h1;
    localparam logic [3:0]  SAM_CNT_LAST  = 4'h7;
    localparam int          SAM_FRAME_ONE = 11;
    localparam int          SAM_FRAME_TWO = 13;
    localparam logic [2:0]  SAM_SYNC_RST  = 3'h0;
    localparam logic        SAM_CSN_RST   = 1'b1;
    localparam logic [7:0]  SAM_CODE_RST  = 8'h00;

    typedef enum logic [2:0] {
        SAM_IDLE   = 3'b000,
        SAM_START  = 3'b001,
        SAM_ADDR   = 3'b010,
        SAM_SETTLE = 3'b011,
        SAM_MSB    = 3'b100,
        SAM_LSB    = 3'b101,
        SAM_TAIL   = 3'b110
    } sam_state_t;

    typedef struct packed {
        logic [SAM_CODE_W-1:0] code;
        logic                  single;
        logic                  polarity;
    } sam_result_t;

    localparam int SAM_RESULT_W = $bits(sam_result_t);
endpackage

// >>> hw/sam_buf2.sv
// Two-entry buffer with registered outputs
`timescale 1ns/100ps
`default_nettype none
module sam_buf2 #(
    parameter int WIDTH = 10
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Fill side
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] tail_r;
    logic [WIDTH-1:0] tail_nxt;
    logic             tail_v_r;
    logic             tail_v_nxt;
    logic [WIDTH-1:0] head_nxt;
    logic             head_v_nxt;
    logic             ready_nxt;

    always_comb begin
        head_nxt   = out_data;
        head_v_nxt = out_valid;
        tail_nxt   = tail_r;
        tail_v_nxt = tail_v_r;
        if (out_valid && out_ready) begin
            if (tail_v_r) begin
                head_nxt   = tail_r;
                tail_v_nxt = 1'b0;
            end else begin
                head_v_nxt = 1'b0;
            end
        end
        if (in_valid && in_ready) begin
            if (!head_v_nxt) begin
                head_nxt   = in_data;
                head_v_nxt = 1'b1;
            end else begin
                tail_nxt   = in_data;
                tail_v_nxt = 1'b1;
            end
        end
        ready_nxt = !tail_v_nxt;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_data  <= '0;
            out_valid <= 1'b0;
            tail_r    <= '0;
            tail_v_r  <= 1'b0;
            in_ready  <= 1'b1;
        end else begin
            out_data  <= head_nxt;
            out_valid <= head_v_nxt;
            tail_r    <= tail_nxt;
            tail_v_r  <= tail_v_nxt;
            in_ready  <= ready_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> sim/sam_conv_properties.sv
// Concurrent checks on the converter pins and result stream
`timescale 1ns/100ps
`default_nettype none
module sam_chk
    import sam_pkg::*;
(
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  nrst,
    // Serial link
    input wire logic                  sclk,
    input wire logic                  cs_n,
    input wire logic                  serial_in,
    input wire logic                  serial_out,
    input wire logic                  serial_out_oe,
    // Analog codes and results
    input wire logic [SAM_CODE_W-1:0] ain0,
    input wire logic [SAM_CODE_W-1:0] ain1,
    input wire logic                  res_valid,
    input wire logic                  res_ready,
    input wire sam_result_t           res_data
);
    logic [SAM_CODE_W-1:0] pos_w;
    logic [SAM_CODE_W-1:0] neg_w;
    assign pos_w = res_data.polarity ? ain1 : ain0;
    assign neg_w = res_data.polarity ? ain0 : ain1;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence lead_s;
        !serial_out_oe ##1 serial_out_oe && !serial_out;
    endsequence
    sequence fresh_s;
        !res_valid ##1 res_valid;
    endsequence
    AST_LEAD_ZERO: assert property (lead_s |-> !serial_out [*3])
        else $error("leading zero missing");
    AST_START_CS: assert property ($rose(serial_out_oe) |-> !cs_n)
        else $error("output enabled while deselected");
    AST_ABORT: assert property (cs_n [*6] |-> !serial_out_oe)
        else $error("output not released");
    AST_IDLE_LOW: assert property (!serial_out_oe [*3] |-> !serial_out)
        else $error("idle output not low");
    AST_SHIFT_FALL: assert property (
        serial_out_oe && $changed(serial_out) |-> !sclk)
        else $error("output changed while clock high");
    AST_SINGLE: assert property (
        fresh_s ##0 res_data.single |-> res_data.code == pos_w)
        else $error("single-ended code wrong");
    AST_DIFF: assert property (
        fresh_s ##0 !res_data.single && pos_w >= neg_w
        |-> res_data.code == pos_w - neg_w)
        else $error("differential code wrong");
    AST_NEG_ZERO: assert property (
        fresh_s ##0 !res_data.single && pos_w < neg_w
        |-> res_data.code == 8'h00)
        else $error("negative difference not zero");
    AST_HOLD: assert property (
        res_valid && !res_ready |=> res_valid && $stable(res_data))
        else $error("result dropped while stalled");
endmodule
bind sam_conv sam_chk i_chk (.clk, .nrst, .sclk, .cs_n, .serial_in,
    .serial_out, .serial_out_oe, .ain0, .ain1, .res_valid, .res_ready,
    .res_data);
`default_nettype wire

// >>> sim/sam_host.sv
// Host model driving the three-wire link
`timescale 1ns/100ps
`default_nettype none
module sam_host (
    // System clock
    input wire logic clk,
    // Link pins
    output var logic sclk,
    output var logic cs_n,
    output var logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    // One-channel device output
    input wire logic serial_out1,
    input wire logic serial_out1_oe
);
    logic [31:0] cap;
    logic [31:0] oec;
    logic [31:0] cap1;
    logic [31:0] oec1;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_in = 1'b0;
        cap = 32'h0;
        oec = 32'h0;
        cap1 = 32'h0;
        oec1 = 32'h0;
    end
    // Frame of n periods: nz zeros, start, word; output seen at rises
    task automatic frame(input int nz, input logic [1:0] w, input int n);
        repeat (8) @(negedge clk);
        cs_n = 1'b0;
        for (int p = 0; p < n; p++) begin
            if (p < nz)
                serial_in = 1'b0;
            else if (p == nz)
                serial_in = 1'b1;
            else if (p <= nz + 2)
                serial_in = w[nz+2-p];
            else
                serial_in = ~serial_in;
            repeat (10) @(negedge clk);
            sclk = 1'b1;
            // Released line reads as the inverse of its last level
            cap = {cap[30:0], serial_out_oe ? serial_out : ~serial_out};
            oec = {oec[30:0], serial_out_oe};
            cap1 = {cap1[30:0], serial_out1_oe ? serial_out1 : ~serial_out1};
            oec1 = {oec1[30:0], serial_out1_oe};
            repeat (10) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (10) @(negedge clk);
        cs_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the serial converter
`timescale 1ns/100ps
`default_nettype none
module testbench
    import sam_pkg::*;
;
    logic                  clk = 1'b0;
    logic                  nrst, sclk, cs_n, serial_in;
    logic                  serial_out, serial_out_oe;
    logic                  res_valid, res_ready;
    logic [SAM_CODE_W-1:0] ain0, ain1;
    sam_result_t           res_data;
    logic                  serial_out1, serial_out1_oe;
    logic                  res1_valid, res1_ready;
    sam_result_t           res1_data, res1_seen;
    int                    fails, n_compared;
    sam_conv #(.TWO_CHAN(1'b1)) i_dut (.clk, .nrst, .sclk, .cs_n,
        .serial_in, .serial_out, .serial_out_oe, .ain0, .ain1,
        .res_valid, .res_ready, .res_data);
    sam_conv #(.TWO_CHAN(1'b0)) i_dut1 (.clk, .nrst, .sclk, .cs_n,
        .serial_in, .serial_out(serial_out1),
        .serial_out_oe(serial_out1_oe), .ain0, .ain1,
        .res_valid(res1_valid), .res_ready(res1_ready),
        .res_data(res1_data));
    sam_host i_host (.clk, .sclk, .cs_n, .serial_in, .serial_out,
        .serial_out_oe, .serial_out1, .serial_out1_oe);
    always #5 clk = ~clk;
    // Last word of the one-channel device
    always @(posedge clk)
        if (res1_valid === 1'b1)
            res1_seen <= res1_data;
    task automatic report_and_stop();
        $display("compared %0d, wrong %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    function automatic logic [7:0] code_of(logic s, logic p);
        logic [7:0] a;
        logic [7:0] b;
        a = p ? ain1 : ain0;
        b = s ? 8'h00 : (p ? ain0 : ain1);
        return (a < b) ? 8'h00 : a - b;
    endfunction
    // Leading zero, MSB first, LSB first without b0, trailing zero
    function automatic logic [16:0] bits_of(logic [7:0] c);
        logic [16:0] e;
        e = {1'b0, c, 8'h00};
        for (int i = 1; i < 8; i++)
            e[8-i] = c[i];
        return e;
    endfunction
    task automatic take(input logic [9:0] exp);
        int k;
        k = 0;
        while (res_valid !== 1'b1 && k < 200) begin
            @(negedge clk);
            k++;
        end
        check(res_valid, 1'b1, "no result");
        if (k == 200)
            report_and_stop();
        check(res_data, exp, "result word");
        res_ready = 1'b1;
        @(negedge clk);
        res_ready = 1'b0;
        @(negedge clk);
    endtask
    task automatic t_conv(input logic s, p, input logic [7:0] a, b,
                          input int nz);
        logic [7:0] c;
        logic [7:0] c1;
        ain0 = a;
        ain1 = b;
        c = code_of(s, p);
        c1 = code_of(1'b0, 1'b0);
        i_host.frame(nz, {s, p}, nz + 20);
        check(i_host.cap[16:0], bits_of(c), "serial bits");
        check(i_host.oec[17:0], 18'h1FFFF, "enable");
        check(i_host.cap1[18:0], {1'b0, c1, 10'h000}, "1ch bits");
        check(i_host.oec1[19:0], 20'h7FFFF, "1ch enable");
        check(res1_seen, {c1, 2'b00}, "1ch word");
        take({c, s, p});
        $display("conversion test done");
    endtask
    task automatic t_full();
        logic [7:0] c;
        ain0 = 8'h5A;
        ain1 = 8'hA5;
        c = code_of(1'b0, 1'b1);
        for (int f = 0; f < 3; f++)
            i_host.frame(0, 2'b01, 20);
        check(i_host.oec[19:0], 20'h0, "frame while full");
        take({c, 2'b01});
        take({c, 2'b01});
        check(res_valid, 1'b0, "extra word");
        $display("full buffer test done");
    endtask
    task automatic t_abort();
        i_host.frame(0, 2'b10, 2);
        repeat (8) @(negedge clk);
        check(res_valid, 1'b0, "word from early abort");
        i_host.frame(0, 2'b10, 6);
        check(i_host.oec[1:0], 2'b11, "enable before abort");
        repeat (8) @(negedge clk);
        check(serial_out_oe, 1'b0, "not released");
        take({code_of(1'b1, 1'b0), 2'b10});
        $display("abort test done");
    endtask
    initial begin
        nrst = 1'b0;
        res_ready = 1'b0;
        res1_ready = 1'b1;
        ain0 = 8'h00;
        ain1 = 8'h00;
        fails = 0;
        n_compared = 0;
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        for (int m = 0; m < 4; m++)
            t_conv(m[1], m[0], 8'hC3, 8'h3C, 0);
        t_conv(1'b0, 1'b0, 8'h81, 8'h02, 3);
        t_full();
        t_abort();
        t_conv(1'b1, 1'b1, 8'h00, 8'hFF, 0);
        report_and_stop();
    end
endmodule
`default_nettype wire
